//--- smbtmp_slave.sv
// Two-wire slave port of a temperature sensor: address match, pointer, registers.
// Assumes bus pins arrive asynchronously and an external master drives the clock line.
// Operation
// - Ignore bus until start condition seen
// - Sample data on clock high, change low
// - Bytes shifted most significant bit first
// - Data line released unless addressed
// - Acknowledge only matching seven-bit address
// - Eighth address bit selects read or write
// - Pull data low during ninth clock
// - Acknowledge data only after it is stored; ack rises with the store, and non-configuration writes are acked but dropped
// - Start, address, data bytes, each acknowledged
// - Command byte is register pointer
// - Fixed default bus address 1001101
// - Temperature is two's complement degrees
`timescale 1ns/100ps
module smbtmp_slave
  import smbtmp_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR   = SMBTMP_DEV_ADDR,
  parameter int         FIFO_DEPTH = SMBTMP_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Sensor side
  input  wire logic [7:0] temp_value,
  input  wire logic       temp_valid,
  output logic            temp_ready,
  output logic            standby,
  output logic            data_ready
);
  if (FIFO_DEPTH < 2) begin : g_depth_chk
    $error("FIFO_DEPTH too small");
  end

  typedef struct packed {
    logic [1:0]    scl_sync;
    logic [1:0]    sda_sync;
    logic          scl_d;
    logic          sda_d;
    smbtmp_state_t state;
    logic [3:0]    bitcnt;
    logic [7:0]    shreg;
    logic [1:0]    bytenum;
    logic          rd;
    logic          matched;
    logic [7:0]    pointer;
    logic [7:0]    temp;
    logic [7:0]    cfg;
    logic          sda_oe;
    logic          temp_ready;
  } smbtmp_st_t;

  smbtmp_st_t st_reg;
  smbtmp_st_t st_next;
  logic       scl;
  logic       sda;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       f_valid;
  logic [7:0] f_data;
  logic       f_pop;
  logic [7:0] rd_byte;

  smbtmp_fifo #(
    .WIDTH (SMBTMP_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (temp_valid && st_reg.temp_ready),
    .in_ready  (),
    .in_data   (temp_value),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  // Second synchroniser stage and edge detection
  assign scl      = st_reg.scl_sync[1];
  assign sda      = st_reg.sda_sync[1];
  assign scl_rise = scl && !st_reg.scl_d;
  assign scl_fall = !scl && st_reg.scl_d;
  assign start_c  = scl && st_reg.scl_d && st_reg.sda_d && !sda;
  assign stop_c   = scl && st_reg.scl_d && !st_reg.sda_d && sda;
  // Drain sensor samples unless standby freezes the reading
  assign f_pop    = f_valid && !st_reg.cfg[SMBTMP_CFG_STBY_BIT];
  assign rd_byte  = (st_reg.pointer == SMBTMP_TEMP_OFFSET) ? st_reg.temp : st_reg.cfg;

  always_comb begin
    st_next          = st_reg;
    st_next.scl_sync = {st_reg.scl_sync[0], scl_in};
    st_next.sda_sync = {st_reg.sda_sync[0], sda_in};
    st_next.scl_d    = scl;
    st_next.sda_d    = sda;
    st_next.temp_ready = !st_reg.cfg[SMBTMP_CFG_STBY_BIT];
    if (f_pop) begin
      st_next.temp = f_data;
      st_next.cfg[SMBTMP_CFG_RDY_BIT] = 1'b1;
    end
    if (start_c) begin
      st_next.state   = SMBTMP_RECV;
      st_next.bitcnt  = 4'h0;
      st_next.bytenum = 2'h0;
      st_next.sda_oe  = 1'b0;
    end else if (stop_c) begin
      st_next.state  = SMBTMP_IDLE;
      st_next.sda_oe = 1'b0;
    end else begin
      unique case (st_reg.state)
        SMBTMP_IDLE: begin
          st_next.sda_oe = 1'b0;
        end
        SMBTMP_RECV: begin
          if (scl_rise) begin
            st_next.shreg  = {st_reg.shreg[6:0], sda};
            st_next.bitcnt = st_reg.bitcnt + 4'h1;
          end else if (scl_fall && st_reg.bitcnt == 4'h8) begin
            st_next.bitcnt = 4'h0;
            if (st_reg.bytenum == 2'h0) begin
              st_next.rd = st_reg.shreg[0];
              if (st_reg.shreg[7:1] == DEV_ADDR) begin
                st_next.sda_oe = 1'b1;
                st_next.state  = SMBTMP_ACK;
              end else begin
                st_next.state  = SMBTMP_IDLE;
              end
            end else if (st_reg.bytenum == 2'h1) begin
              st_next.pointer = st_reg.shreg;
              st_next.sda_oe  = 1'b1;
              st_next.state   = SMBTMP_ACK;
            end else begin
              if (st_reg.pointer == SMBTMP_CFG_OFFSET) begin
                // Keeps a ready flag set by a sample loaded in this same cycle
                st_next.cfg = (st_next.cfg & ~SMBTMP_CFG_WMASK) | (st_reg.shreg & SMBTMP_CFG_WMASK);
                if (st_reg.shreg[SMBTMP_CFG_STBY_BIT] && !st_reg.cfg[SMBTMP_CFG_STBY_BIT] && !f_pop) begin
                  st_next.cfg[SMBTMP_CFG_RDY_BIT] = 1'b0;
                end
              end
              st_next.sda_oe = 1'b1;
              st_next.state  = SMBTMP_ACK;
            end
          end
        end
        SMBTMP_ACK: begin
          if (scl_fall) begin
            st_next.sda_oe  = 1'b0;
            st_next.bytenum = (st_reg.bytenum == 2'h2) ? 2'h2 : st_reg.bytenum + 2'h1;
            if (st_reg.bytenum == 2'h0 && st_reg.rd) begin
              st_next.shreg  = {rd_byte[6:0], 1'b0};
              st_next.sda_oe = !rd_byte[7];
              st_next.bitcnt = 4'h1;
              st_next.state  = SMBTMP_SEND;
            end else begin
              st_next.state = SMBTMP_RECV;
            end
          end
        end
        SMBTMP_SEND: begin
          if (scl_fall) begin
            if (st_reg.bitcnt == 4'h8) begin
              st_next.sda_oe = 1'b0;
              st_next.state  = SMBTMP_MACK;
            end else begin
              st_next.sda_oe = !st_reg.shreg[7];
              st_next.shreg  = {st_reg.shreg[6:0], 1'b0};
              st_next.bitcnt = st_reg.bitcnt + 4'h1;
            end
          end
        end
        SMBTMP_MACK: begin
          if (scl_rise) begin
            st_next.state = sda ? SMBTMP_IDLE : SMBTMP_MACK;
          end else if (scl_fall) begin
            st_next.shreg  = {rd_byte[6:0], 1'b0};
            st_next.sda_oe = !rd_byte[7];
            st_next.bitcnt = 4'h1;
            st_next.state  = SMBTMP_SEND;
          end
        end
        default: begin
          st_next.state  = SMBTMP_IDLE;
          st_next.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg          <= '0;
      st_reg.scl_sync <= 2'h3;
      st_reg.sda_sync <= 2'h3;
      st_reg.scl_d    <= 1'b1;
      st_reg.sda_d    <= 1'b1;
      st_reg.state    <= SMBTMP_IDLE;
      st_reg.temp     <= SMBTMP_TEMP_RESET;
      st_reg.cfg      <= SMBTMP_CFG_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Open-drain: only ever pulls low, clock line never driven
  assign sda_out    = 1'b0;
  assign sda_oe     = st_reg.sda_oe;
  assign temp_ready = st_reg.temp_ready;
  assign standby    = st_reg.cfg[SMBTMP_CFG_STBY_BIT];
  assign data_ready = st_reg.cfg[SMBTMP_CFG_RDY_BIT];
endmodule : smbtmp_slave

//--- smbtmp_pkg.sv
// Constants for the sensor two-wire slave port.
// Assumes a 250 MHz system clock sampling the bus pins.
package smbtmp_pkg;
  localparam logic [6:0] SMBTMP_DEV_ADDR      = 7'h4d;
  localparam logic [7:0] SMBTMP_TEMP_OFFSET   = 8'h00;
  localparam logic [7:0] SMBTMP_CFG_OFFSET    = 8'h01;
  localparam logic [7:0] SMBTMP_TEMP_RESET    = 8'h00;
  localparam logic [7:0] SMBTMP_CFG_RESET     = 8'h00;
  localparam logic [7:0] SMBTMP_CFG_WMASK     = 8'h80;
  localparam int         SMBTMP_CFG_RDY_BIT   = 6;
  localparam int         SMBTMP_CFG_STBY_BIT  = 7;
  localparam int         SMBTMP_FIFO_WIDTH    = 8;
  localparam int         SMBTMP_FIFO_DEPTH    = 8;
  localparam int         SMBTMP_MCLK_MHZ      = 250;

  typedef enum logic [2:0] {
    SMBTMP_IDLE = 3'h0,
    SMBTMP_RECV = 3'h1,
    SMBTMP_ACK  = 3'h2,
    SMBTMP_SEND = 3'h3,
    SMBTMP_MACK = 3'h4
  } smbtmp_state_t;
endpackage : smbtmp_pkg

//--- smbtmp_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/100ps
module smbtmp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
    $error("DEPTH must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [AW:0] wptr;
    logic [AW:0] rptr;
  } smbtmp_fifo_st_t;

  smbtmp_fifo_st_t  st_reg;
  smbtmp_fifo_st_t  st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = (st_reg.wptr - st_reg.rptr) != (AW+1)'(DEPTH);
  assign out_valid = st_reg.wptr != st_reg.rptr;
  assign out_data  = mem[st_reg.rptr[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) st_next.wptr = st_reg.wptr + 1'b1;
    if (pop) st_next.rptr = st_reg.rptr + 1'b1;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) mem[st_reg.wptr[AW-1:0]] <= in_data;
  end
endmodule : smbtmp_fifo

//--- smbtmp_slave_properties.sv
// Checker on the slave port's top-level pins.
// Assumes it is bound from the testbench top.
`timescale 1ns/100ps
module smbtmp_slave_properties
  import smbtmp_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR   = SMBTMP_DEV_ADDR,
  parameter int         FIFO_DEPTH = SMBTMP_FIFO_DEPTH
) (
  // Clock, reset and bus
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // Sensor side
  input wire logic [7:0] temp_value,
  input wire logic       temp_valid,
  input wire logic       temp_ready,
  input wire logic       standby,
  input wire logic       data_ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence stop_s;
    scl_in && $rose(sda_in);
  endsequence
  sequence after_fall_s;
    !scl_in && $past(scl_in, 8);
  endsequence
  open_drain_a: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  oe_after_fall_a: assert property ($changed(sda_oe) |-> after_fall_s)
    else $error("data pin moved outside clock low");
  oe_steady_high_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data pin moved in clock high");
  stop_release_a: assert property (stop_s |-> !sda_oe [*8])
    else $error("data pin held after stop");
  reset_quiet_a: assert property (disable iff (1'b0)
    rst ##1 rst |-> !sda_oe && !standby && !data_ready && !temp_ready)
    else $error("outputs active in reset");
  store_ack_a: assert property ($rose(standby) |-> sda_oe && (!data_ready || $past(temp_valid, 2)))
    else $error("no acknowledge after store");
  sample_flag_a: assert property (temp_valid && temp_ready && !standby |-> ##[1:20] data_ready)
    else $error("sample not flagged");
  standby_hold_a: assert property (standby && $past(standby) |-> !temp_ready)
    else $error("samples taken in standby");
endmodule : smbtmp_slave_properties

//--- smbtmp_master_model.sv
// Bus master model: makes the clock, start, stop and bytes.
// Assumes a pull-up resolves the data wire outside.
`timescale 1ns/100ps
module smbtmp_master_model (
  // Bus pins
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda
);
  logic [8:0] res;
  event       done;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // One bit, 160 ns, clock also driven by start and stop
  task automatic bit_x(input logic b, output logic r);
    #40 sda_drv = b;
    #40 scl = 1'b1;
    #40 r = sda;
    #40 scl = 1'b0;
  endtask : bit_x
  task automatic start;
    #40 sda_drv = 1'b1;
    #40 scl = 1'b1;
    #40 sda_drv = 1'b0;
    #40 scl = 1'b0;
  endtask : start
  task automatic stop;
    #40 sda_drv = 1'b0;
    #40 scl = 1'b1;
    #40 sda_drv = 1'b1;
    #40;
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic m);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      res[i] = r;
    end
    bit_x(m, r);
    res[8] = r;
    -> done;
  endtask : xfer
endmodule : smbtmp_master_model

//--- smbtmp_slave_tb_top.sv
// Testbench for the sensor slave port.
// Assumes the master model and a pulled-up data wire.
`timescale 1ns/100ps
module smbtmp_slave_tb_top
  import smbtmp_pkg::*;
;
  localparam logic [7:0] AW = {SMBTMP_DEV_ADDR, 1'b0};
  logic        mclk = 1'b0, rst = 1'b1, temp_valid = 1'b0;
  logic        scl, sda_drv, sda_oe, sda_out, temp_ready, standby, data_ready;
  logic [7:0]  temp_value = 8'h00;
  logic [31:0] seed = 32'ha6ad21bb;
  logic [8:0]  exp_q[$];
  int          err_count = 0, comparisons = 0;
  wire         sda = sda_drv & ~(sda_oe & ~sda_out);
  always #2 mclk = ~mclk;
  smbtmp_slave smbtmp_slave_i (.mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .temp_value(temp_value), .temp_valid(temp_valid), .temp_ready(temp_ready),
    .standby(standby), .data_ready(data_ready));
  smbtmp_master_model smbtmp_master_model_i (.scl(scl), .sda_drv(sda_drv), .sda(sda));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [8:0] seen, input logic [8:0] expd);
    comparisons++;
    if (seen !== expd) begin
      err_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, expd);
    end
  endtask : check
  task automatic finish_test;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic xb(input logic [7:0] d, input logic m, input logic [8:0] e);
    exp_q.push_back(e);
    smbtmp_master_model_i.xfer(d, m);
  endtask : xb
  task automatic hdr(input logic [7:0] a, input logic nak);
    smbtmp_master_model_i.start();
    xb(a, 1'b1, {nak, a});
  endtask : hdr
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    hdr(AW, 1'b0);
    xb(p, 1'b1, {1'b0, p});
    xb(d, 1'b1, {1'b0, d});
    smbtmp_master_model_i.stop();
  endtask : wr
  task automatic rd(input logic set, input logic [7:0] p, input logic [7:0] e);
    if (set) begin
      hdr(AW, 1'b0);
      xb(p, 1'b1, {1'b0, p});
    end
    hdr(AW | 8'h01, 1'b0);
    xb(8'hff, 1'b0, {1'b0, e});
    xb(8'hff, 1'b1, {1'b1, e});
    smbtmp_master_model_i.stop();
  endtask : rd
  task automatic sample(input logic [7:0] v);
    @(posedge mclk) #1;
    temp_value = v;
    temp_valid = 1'b1;
    @(posedge mclk) #1;
    temp_valid = 1'b0;
    repeat (30) @(posedge mclk);
    #1;
  endtask : sample
  always @(smbtmp_master_model_i.done) begin
    check(smbtmp_master_model_i.res, exp_q.pop_front());
  end
  initial begin
    #300000;
    err_count++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge mclk);
    #1 rst = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    rd(1'b1, SMBTMP_CFG_OFFSET, SMBTMP_CFG_RESET);
    rd(1'b1, SMBTMP_TEMP_OFFSET, SMBTMP_TEMP_RESET);
    $display("test reset values done");
    hdr(AW ^ 8'h02, 1'b1);
    xb(8'h00, 1'b1, 9'h100);
    smbtmp_master_model_i.stop();
    $display("test foreign address done");
    seed = lfsr(seed);
    sample(seed[7:0]);
    rd(1'b1, SMBTMP_TEMP_OFFSET, seed[7:0]);
    rd(1'b1, SMBTMP_CFG_OFFSET, 8'h01 << SMBTMP_CFG_RDY_BIT);
    wr(SMBTMP_CFG_OFFSET, 8'hff);
    rd(1'b0, 8'h00, SMBTMP_CFG_WMASK);
    sample(~seed[7:0]);
    rd(1'b1, SMBTMP_TEMP_OFFSET, seed[7:0]);
    wr(SMBTMP_TEMP_OFFSET, 8'h5a);
    rd(1'b0, 8'h00, seed[7:0]);
    wr(SMBTMP_CFG_OFFSET, 8'h00);
    $display("test registers done");
    if (exp_q.size() != 0) err_count++;
    finish_test();
  end
endmodule : smbtmp_slave_tb_top
bind smbtmp_slave smbtmp_slave_properties #(.DEV_ADDR(DEV_ADDR), .FIFO_DEPTH(FIFO_DEPTH)) smbtmp_slave_properties_i (
  .mclk(mclk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .temp_value(temp_value), .temp_valid(temp_valid), .temp_ready(temp_ready), .standby(standby),
  .data_ready(data_ready));
